/* File: design/alfh_frame_handler.sv */
// Purpose: device side ascii request/reply framer with delay and alarm
// Assumes: rx bytes one cycle valid; tx bytes taken on tx_ready_in
// Notes: hex letters must be upper case
//
// The implementer's own choices: strobed register access and the register addresses.
module alfh_frame_handler
	import alfh_pkg::*;
#(
	parameter int MS_CYC = MS_CYC_DEF
)
(
	input wire logic mclk_in, // system clock
	input wire logic rst_n_in, // sync reset, low
	input wire logic [2:0] reg_addr_in, // register index
	input wire logic [31:0] reg_wdata_in, // write data
	input wire logic reg_wr_in, // write strobe
	input wire logic reg_rd_in, // read strobe
	output logic [31:0] reg_rdata_out, // read data, next cycle
	input wire logic [7:0] rx_byte_in, // received character
	input wire logic rx_valid_in, // character strobe
	output logic [7:0] tx_byte_out, // character to send
	output logic tx_valid_out, // character offered
	input wire logic tx_ready_in, // uart takes character
	input wire logic [15:0] mon_data_in, // value for read replies
	output alfh_cmd_s cmd_out, // accepted instruction
	output logic cmd_valid_out, // one cycle pulse
	output logic alarm_out, // alarm stop level
	output logic irq_out // interrupt level
);
	localparam int TW = $clog2(MS_CYC + 1);
	if (MS_CYC < 1)
	begin : g_bad_ms
		$error("MS_CYC must be at least one");
	end

	function automatic logic is_hex(input logic [7:0] c);
		return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
	endfunction : is_hex

	function automatic logic [3:0] hex2nib(input logic [7:0] c);
		logic [7:0] d;
		d = c - 8'h37;
		return (c <= 8'h39) ? c[3:0] : d[3:0];
	endfunction : hex2nib

	function automatic logic [7:0] nib2hex(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction : nib2hex

	function automatic logic [1:0] term_len(input logic [1:0] t);
		return (t == TERM_CR) ? 2'h1 : ((t == TERM_CRLF) ? 2'h2 : 2'h0);
	endfunction : term_len

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	alfh_state_e state_r;
	logic [4:0] idx_r, stn_r;
	logic [15:0] acc_r, data_r, limit_r, dly_set_r, retry_cnt_r, derr_cnt_r;
	logic [7:0] sum_r, ins_r, dly_ms_r, tx_byte_r, bank_r;
	logic [3:0] err_r, wait_r, tx_len_r, tx_idx_r;
	logic ans_nak_r, tx_valid_r, rd_reply_r, alarm_r, cmd_valid_r, irq_r;
	logic [TW-1:0] tick_r;
	logic [7:0] tx_buf_r [0:11];
	logic [1:0] term_r;
	alfh_cmd_s cmd_r;
	logic [IRQ_W-1:0] irq_st_r, irq_mask_r;
	logic [31:0] rdata_r;

	// ---------------------------------------------------------------
	// character classification
	// ---------------------------------------------------------------
	logic w_present, enq, stn_hit, last, listen;
	logic [3:0] nib, c_err, new_err;
	logic [2:0] dl;
	logic [4:0] ss, ts, fe;
	always_comb
	begin
		w_present = dly_set_r == VAL_9999; // RULE_09
		nib = hex2nib(rx_byte_in); // RULE_02
		listen = state_r == ST_IDLE || state_r == ST_RX || state_r == ST_ANS;
		enq = listen && rx_valid_in && rx_byte_in == CH_ENQ; // RULE_04 RULE_01
		dl = ins_r[7] ? ((ins_r == INS_BANK_WR) ? 3'h2 : 3'h4) : 3'h0; // RULE_07
		ss = (w_present ? 5'h05 : 5'h04) + {2'h0, dl};
		ts = (state_r == ST_ANS) ? 5'h03 : ss + 5'h02;
		fe = ts + {3'h0, term_len(term_r)}; // RULE_06
		stn_hit = {acc_r[3:0], nib} == {3'h0, stn_r};
		c_err = ERR_NONE;
		if (state_r == ST_ANS && idx_r == 5'h00)
		begin
			if (rx_byte_in != CH_ACK && rx_byte_in != CH_NAK)
				c_err = ERR_FMT;
		end
		else if (idx_r < ts)
		begin
			if (!is_hex(rx_byte_in))
				c_err = ERR_FMT;
			else if (state_r == ST_RX && idx_r == ss + 5'h01 && {acc_r[3:0], nib} != sum_r)
				c_err = ERR_SUM; // RULE_10
			else if (state_r == ST_ANS && idx_r == 5'h02 && !stn_hit)
				c_err = ERR_FMT;
		end
		else if (rx_byte_in != ((idx_r == ts) ? CH_CR : CH_LF))
			c_err = ERR_FMT; // RULE_06
		new_err = (err_r != ERR_NONE) ? err_r : c_err;
		last = rx_valid_in && !enq && idx_r == fe - 5'h01;
	end

	logic fin, fin_ok, ans_fin, ans_bad, go_tx, tx_last, lim_on, retry_alarm, derr_alarm, aclr;
	logic [15:0] retry_inc, derr_inc;
	assign fin = state_r == ST_RX && last;
	assign fin_ok = fin && new_err == ERR_NONE;
	assign ans_fin = state_r == ST_ANS && last;
	assign ans_bad = new_err != ERR_NONE || ans_nak_r;
	assign go_tx = state_r == ST_DELAY && dly_ms_r == 8'h00;
	assign tx_last = state_r == ST_TX && tx_valid_r && tx_ready_in && tx_idx_r == tx_len_r - 4'h1;
	assign lim_on = limit_r != VAL_9999;
	assign retry_inc = (retry_cnt_r == 16'hFFFF) ? retry_cnt_r : retry_cnt_r + 16'h0001;
	assign derr_inc = (derr_cnt_r == 16'hFFFF) ? derr_cnt_r : derr_cnt_r + 16'h0001;
	assign retry_alarm = fin && !fin_ok && lim_on && retry_inc > limit_r; // RULE_14
	assign derr_alarm = ans_fin && ans_bad && lim_on && derr_inc >= limit_r; // RULE_15
	assign aclr = reg_wr_in && reg_addr_in == OFS_CFG && reg_wdata_in[CFG_ACLR_BIT];

	// ---------------------------------------------------------------
	// field capture
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in || enq || (tx_last && rd_reply_r))
		begin
			idx_r <= 5'h00;
			acc_r <= 16'h0000;
			sum_r <= 8'h00;
			err_r <= ERR_NONE;
		end
		else if (rx_valid_in && (state_r == ST_RX || state_r == ST_ANS))
		begin
			idx_r <= idx_r + 5'h01;
			acc_r <= (state_r == ST_RX && idx_r == 5'h03) ? 16'h0000 : {acc_r[11:0], nib};
			if (state_r == ST_RX && idx_r < ss)
				sum_r <= sum_r + rx_byte_in; // RULE_10
			err_r <= new_err;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			ins_r <= 8'h00;
			wait_r <= 4'h0;
			data_r <= 16'h0000;
			ans_nak_r <= 1'b0;
		end
		else if (rx_valid_in && !enq)
		begin
			if (state_r == ST_RX && idx_r == 5'h03)
				ins_r <= {acc_r[3:0], nib};
			if (state_r == ST_RX && w_present && idx_r == 5'h04)
				wait_r <= nib; // RULE_08
			if (state_r == ST_RX && dl != 3'h0 && idx_r == ss - 5'h01)
				data_r <= {acc_r[11:0], nib};
			if (state_r == ST_ANS && idx_r == 5'h00)
				ans_nak_r <= rx_byte_in == CH_NAK;
		end
	end

	// ---------------------------------------------------------------
	// reply assembly
	// ---------------------------------------------------------------
	logic [7:0] rb [0:11];
	logic [3:0] k;
	logic [7:0] rs;
	logic [15:0] rdv;
	logic [2:0] rdl;
	always_comb
	begin
		for (int j = 0; j < 12; j++)
			rb[j] = 8'h00;
		rdv = (ins_r == INS_BANK_RD) ? {8'h00, bank_r} : mon_data_in; // RULE_17
		rdl = (ins_r == INS_BANK_RD) ? 3'h2 : 3'h4;
		rb[0] = (err_r != ERR_NONE) ? CH_NAK : (ins_r[7] ? CH_ACK : CH_STX); // RULE_05
		rb[1] = nib2hex({3'h0, stn_r[4]});
		rb[2] = nib2hex(stn_r[3:0]);
		rs = rb[1] + rb[2];
		k = 4'h3;
		if (err_r != ERR_NONE)
		begin
			rb[3] = nib2hex(err_r); // RULE_11
			k = 4'h4;
		end
		else if (!ins_r[7])
		begin
			for (int i = 3; i >= 0; i--)
				if (3'(i) < rdl)
				begin
					rb[k] = nib2hex(rdv[i*4 +: 4]); // RULE_02
					rs = rs + rb[k];
					k = k + 4'h1;
				end
			rb[k] = CH_ETX;
			rs = rs + CH_ETX;
			rb[k + 4'h1] = nib2hex(rs[7:4]);
			rb[k + 4'h2] = nib2hex(rs[3:0]);
			k = k + 4'h3;
		end
		if (term_len(term_r) != 2'h0)
		begin
			rb[k] = CH_CR;
			k = k + 4'h1;
		end
		if (term_len(term_r) == 2'h2)
		begin
			rb[k] = CH_LF;
			k = k + 4'h1;
		end
	end

	// ---------------------------------------------------------------
	// sequencing
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			state_r <= ST_IDLE;
			dly_ms_r <= 8'h00;
			tick_r <= '0;
			tx_len_r <= 4'h0;
			tx_idx_r <= 4'h0;
			tx_byte_r <= 8'h00;
			tx_valid_r <= 1'b0;
			rd_reply_r <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE, ST_RX, ST_ANS:
				begin
					if (enq)
						state_r <= ST_RX; // RULE_04
					else if (state_r == ST_RX && rx_valid_in && idx_r == 5'h01 && !stn_hit)
						state_r <= ST_IDLE; // RULE_03
					else if (fin)
					begin
						// reset instruction gets no reply
						state_r <= (fin_ok && ins_r == INS_RESET) ? ST_IDLE : ST_DELAY;
						tick_r <= '0;
						if (w_present)
							dly_ms_r <= 8'(wait_r * WAIT_STEP_MS); // RULE_08
						else
							dly_ms_r <= (dly_set_r > {8'h00, DLY_MAX_MS}) ? DLY_MAX_MS : dly_set_r[7:0];
					end
					else if (ans_fin)
					begin
						tx_idx_r <= 4'h0;
						state_r <= (ans_bad && !derr_alarm) ? ST_TX : ST_IDLE; // RULE_15
					end
				end
				ST_DELAY:
				begin
					if (go_tx)
					begin
						state_r <= ST_TX; // RULE_01
						for (int j = 0; j < 12; j++)
							tx_buf_r[j] <= rb[j];
						tx_len_r <= k;
						tx_idx_r <= 4'h0;
						rd_reply_r <= err_r == ERR_NONE && !ins_r[7]; // RULE_16
					end
					else if (tick_r == TW'(MS_CYC - 1))
					begin
						tick_r <= '0;
						dly_ms_r <= dly_ms_r - 8'h01;
					end
					else
						tick_r <= tick_r + TW'(1);
				end
				ST_TX:
				begin
					// one idle cycle per character keeps the buffer read registered
					if (!tx_valid_r)
					begin
						tx_byte_r <= tx_buf_r[tx_idx_r];
						tx_valid_r <= 1'b1;
					end
					else if (tx_ready_in)
					begin
						tx_valid_r <= 1'b0;
						tx_idx_r <= tx_idx_r + 4'h1;
						if (tx_last)
							state_r <= rd_reply_r ? ST_ANS : ST_IDLE;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// commands and bank
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			cmd_r <= '0;
			cmd_valid_r <= 1'b0;
			bank_r <= 8'h00;
		end
		else
		begin
			cmd_valid_r <= fin_ok && ins_r != INS_BANK_WR; // RULE_12 RULE_07
			if (fin_ok)
				cmd_r <= '{code: ins_r, data: data_r};
			if (fin_ok && ins_r == INS_BANK_WR)
				bank_r <= data_r[7:0]; // RULE_17
		end
	end

	// ---------------------------------------------------------------
	// error counting and alarm
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			retry_cnt_r <= 16'h0000;
			derr_cnt_r <= 16'h0000;
			alarm_r <= 1'b0;
		end
		else
		begin
			if (fin)
				retry_cnt_r <= fin_ok ? 16'h0000 : retry_inc; // RULE_18 RULE_14
			else if (aclr || (ans_fin && !ans_bad))
				retry_cnt_r <= 16'h0000;
			if (ans_fin)
				derr_cnt_r <= ans_bad ? derr_inc : 16'h0000; // RULE_18 RULE_15
			else if (aclr || fin_ok)
				derr_cnt_r <= 16'h0000;
			// a new alarm wins over a software clear in the same cycle
			alarm_r <= retry_alarm || derr_alarm || (alarm_r && !aclr);
		end
	end

	// ---------------------------------------------------------------
	// registers and interrupt
	// ---------------------------------------------------------------
	logic [IRQ_W-1:0] ev, irq_st_nxt, irq_mask_nxt;
	always_comb
	begin
		ev = {ans_fin && ans_bad, ans_fin && !ans_bad, retry_alarm || derr_alarm, fin && !fin_ok, fin_ok};
		irq_st_nxt = irq_st_r;
		if (reg_wr_in && reg_addr_in == OFS_IRQ_ST)
			irq_st_nxt = irq_st_r & ~reg_wdata_in[IRQ_W-1:0];
		irq_st_nxt = irq_st_nxt | ev;
		irq_mask_nxt = (reg_wr_in && reg_addr_in == OFS_IRQ_MASK) ? reg_wdata_in[IRQ_W-1:0] : irq_mask_r;
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			stn_r <= 5'h00;
			term_r <= 2'h0;
			limit_r <= RST_LIMIT;
			dly_set_r <= RST_DELAY;
			irq_st_r <= '0;
			irq_mask_r <= '0;
			irq_r <= 1'b0;
		end
		else
		begin
			irq_st_r <= irq_st_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq_r <= |(irq_st_nxt & irq_mask_nxt);
			if (reg_wr_in && reg_addr_in == OFS_CFG)
			begin
				stn_r <= reg_wdata_in[4:0]; // RULE_03
				term_r <= reg_wdata_in[6:5];
			end
			if (reg_wr_in && reg_addr_in == OFS_LIMIT)
				limit_r <= reg_wdata_in[15:0];
			if (reg_wr_in && reg_addr_in == OFS_DELAY)
				dly_set_r <= reg_wdata_in[15:0];
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			rdata_r <= 32'h0000_0000;
		else if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				OFS_CFG: rdata_r <= {25'h0, term_r, stn_r};
				OFS_LIMIT: rdata_r <= {16'h0000, limit_r};
				OFS_DELAY: rdata_r <= {16'h0000, dly_set_r};
				OFS_STATUS: rdata_r <= {8'h00, bank_r, 4'h0, err_r, 6'h00, state_r != ST_IDLE, alarm_r};
				OFS_IRQ_ST: rdata_r <= {27'h0, irq_st_r};
				OFS_IRQ_MASK: rdata_r <= {27'h0, irq_mask_r};
				OFS_COUNT: rdata_r <= {derr_cnt_r, retry_cnt_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign reg_rdata_out = rdata_r;
	assign tx_byte_out = tx_byte_r;
	assign tx_valid_out = tx_valid_r;
	assign cmd_out = cmd_r;
	assign cmd_valid_out = cmd_valid_r;
	assign alarm_out = alarm_r;
	assign irq_out = irq_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	AST_QUIET_IDLE: assert property ((state_r == ST_IDLE) |-> !tx_valid_out) // RULE_01
		else $error("tx active while idle");
	AST_STN_DROP: assert property (state_r == ST_RX && rx_valid_in && !enq && idx_r == 5'h01 && !stn_hit
		|=> state_r == ST_IDLE) // RULE_03
		else $error("foreign station not dropped");
	AST_ENQ_OPEN: assert property (enq |=> state_r == ST_RX && idx_r == 5'h00) // RULE_04
		else $error("enquiry did not open a frame");
	AST_NAK_HEAD: assert property (go_tx && err_r != ERR_NONE |=> tx_buf_r[0] == CH_NAK) // RULE_11
		else $error("bad frame not answered by nak");
	AST_NO_CMD_BAD: assert property (cmd_valid_out |-> $past(fin_ok)) // RULE_12
		else $error("command from rejected frame");
	AST_RETRY_ALARM: assert property (retry_alarm |=> alarm_out && retry_cnt_r > limit_r) // RULE_14
		else $error("retry limit did not raise alarm");
	AST_DERR_ALARM: assert property (derr_alarm |=> alarm_out ##1 state_r != ST_TX) // RULE_15
		else $error("reply error limit did not stop");
	AST_COUNT_CLEAR: assert property (fin_ok |=> retry_cnt_r == 16'h0000 && derr_cnt_r == 16'h0000) // RULE_18
		else $error("counters not cleared");
	AST_BANK_WRITE: assert property (fin_ok && ins_r == INS_BANK_WR |=> bank_r == $past(data_r[7:0])) // RULE_17
		else $error("bank not written");
	AST_DELAY_END: assert property (state_r == ST_DELAY && dly_ms_r == 8'h00 |=> state_r == ST_TX) // RULE_08
		else $error("reply not started after delay");
	COV_GOOD_WRITE: cover property (fin_ok && ins_r[7]);
	COV_READ_ACKED: cover property (ans_fin && !ans_bad);
	COV_RESEND: cover property (ans_fin && ans_bad ##1 state_r == ST_TX);
	COV_ALARM: cover property ($rose(alarm_out));
endmodule : alfh_frame_handler

/* File: inc/alfh_pkg.sv */
// Purpose: constants and types for the ascii link frame handler
// Assumes: 50 MHz mclk_in; characters arrive already deframed by a uart
// Notes: offsets are word indices on the plain register port
//
// Summary of operation
// [RULE_01] never transmit unless a request arrived
// [RULE_02] all fields travel as ascii hex digits
// [RULE_03] act only on own station 00H..1FH
// [RULE_04] STX 02H, ETX 03H, ENQ 05H opens request
// [RULE_05] ACK 06H means good, NAK 15H bad
// [RULE_06] selectable terminator: none, CR, CR+LF
// [RULE_07] instruction code picks operation and data size
// [RULE_08] waiting digit delays reply by 10ms steps
// [RULE_09] stored delay not 9999 drops waiting digit
// [RULE_10] two hex digits carry low sum byte
// [RULE_11] bad request answered NAK plus error code
// [RULE_12] bad request changes no state
// [RULE_13] host retransmits after NAK itself
// [RULE_14] retries above limit raise alarm stop
// [RULE_15] host NAK resends reply; limit raises alarm
// [RULE_16] host answers only read replies
// [RULE_17] bank read 7FH, written FFH
// [RULE_18] good frame clears error and retry counts
package alfh_pkg;
	localparam logic [7:0] CH_STX = 8'h02;
	localparam logic [7:0] CH_ETX = 8'h03;
	localparam logic [7:0] CH_ENQ = 8'h05;
	localparam logic [7:0] CH_ACK = 8'h06;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_NAK = 8'h15;
	localparam logic [7:0] INS_BANK_RD = 8'h7F;
	localparam logic [7:0] INS_BANK_WR = 8'hFF;
	localparam logic [7:0] INS_RESET = 8'hFD;
	localparam logic [15:0] VAL_9999 = 16'h270F;
	localparam logic [7:0] DLY_MAX_MS = 8'h96;
	localparam logic [7:0] WAIT_STEP_MS = 8'h0A;
	localparam int CLK_HZ = 50000000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYC_DEF = CLK_HZ / MS_PER_S;
	localparam logic [1:0] TERM_CR = 2'h1;
	localparam logic [1:0] TERM_CRLF = 2'h2;
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_SUM = 4'h1;
	localparam logic [3:0] ERR_FMT = 4'h2;
	localparam logic [2:0] OFS_CFG = 3'h0;
	localparam logic [2:0] OFS_LIMIT = 3'h1;
	localparam logic [2:0] OFS_DELAY = 3'h2;
	localparam logic [2:0] OFS_STATUS = 3'h3;
	localparam logic [2:0] OFS_IRQ_ST = 3'h4;
	localparam logic [2:0] OFS_IRQ_MASK = 3'h5;
	localparam logic [2:0] OFS_COUNT = 3'h6;
	localparam int CFG_ACLR_BIT = 8;
	localparam int IRQ_W = 5;
	localparam logic [15:0] RST_LIMIT = VAL_9999;
	localparam logic [15:0] RST_DELAY = VAL_9999;
	typedef struct packed {
		logic [7:0] code;
		logic [15:0] data;
	} alfh_cmd_s;
	typedef enum {ST_IDLE, ST_RX, ST_DELAY, ST_TX, ST_ANS} alfh_state_e;
endpackage : alfh_pkg

/* File: testbench/alfh_frame_handler_test.sv */
// Purpose: self-checking bench for the ascii link frame handler
// Assumes: MS_CYC shortened to 4 clocks per ms
// Notes: replies, commands and reads are noted in queues and checked by one watcher
module alfh_frame_handler_test
	import alfh_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MSC = 4;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [2:0] reg_addr_in = 3'h0;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [15:0] mon_data_in = 16'h0;
	logic [1:0] term = 2'h0;
	logic slow = 1'b0;
	logic [31:0] reg_rdata_out;
	logic [7:0] rx_byte_in;
	logic [7:0] tx_byte_out;
	logic rx_valid_in, tx_valid_out, tx_ready_in, cmd_valid_out, alarm_out, irq_out;
	logic rd_d = 1'b0;
	alfh_cmd_s cmd_out;
	logic [7:0] q_tx[$];
	logic [47:0] q_cmd[$];
	logic [31:0] q_rd[$];
	logic [47:0] ce;
	logic [31:0] xr = 32'h10;
	logic [31:0] v;
	logic [31:0] rv[8] = '{32'h0, 32'h270F, 32'h270F, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	int n_mismatch = 0;
	int checks = 0;
	int cyc = 0;
	always #10 mclk_in = ~mclk_in;
	alfh_frame_handler #(.MS_CYC(MSC)) DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.rx_byte_in(rx_byte_in), .rx_valid_in(rx_valid_in), .tx_byte_out(tx_byte_out), .tx_valid_out(tx_valid_out),
		.tx_ready_in(tx_ready_in), .mon_data_in(mon_data_in), .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out),
		.alarm_out(alarm_out), .irq_out(irq_out));
	alfh_host_model HOST (.mclk_in(mclk_in), .term_in(term), .slow_in(slow), .rx_byte_out(rx_byte_in),
		.rx_valid_out(rx_valid_in), .tx_ready_out(tx_ready_in));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("mismatches=%0d checks=%0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	// ----------------------------------------
	// watcher: every reply char, command and read
	// ----------------------------------------
	always @(posedge mclk_in)
	begin
		if (tx_valid_out === 1'b1 && tx_ready_in)
		begin
			if (q_tx.size() == 0)
				chk({24'h0, tx_byte_out}, 32'h100);
			else
				chk({24'h0, tx_byte_out}, {24'h0, q_tx.pop_front()});
		end
		if (rst_n_in && cmd_valid_out !== 1'b0)
		begin
			ce = (q_cmd.size() == 0) ? 48'h0 : q_cmd.pop_front();
			chk({8'h0, cmd_out & ce[47:24]}, {7'h0, q_cmd.size() == 0 && ce == 48'h0, ce[23:0]});
		end
		rd_d <= reg_rd_in;
		if (rd_d)
			chk(reg_rdata_out, q_rd.pop_front());
		cyc++;
		if (cyc == 60000)
		begin
			n_mismatch++;
			stop_test();
		end
	end
	function automatic logic [31:0] xs();
		xr ^= xr << 13;
		xr ^= xr >> 17;
		xr ^= xr << 5;
		return xr;
	endfunction : xs
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [31:0] e);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		q_rd.push_back(e);
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
	endtask : rd
	task automatic settle();
		repeat (3) @(negedge mclk_in);
	endtask : settle
	// bounded wait for all noted reply chars; silent frames just idle it out
	task automatic drain();
		for (int i = 0; i < 4000 && q_tx.size() > 0; i++)
			@(posedge mclk_in);
		repeat (12) @(posedge mclk_in);
		chk(32'(q_tx.size()), 32'h0);
	endtask : drain
	task automatic lat(input int d);
		int n;
		n = 0;
		while (tx_valid_out !== 1'b1 && n < 2000)
		begin
			@(negedge mclk_in);
			n++;
		end
		chk(32'(n >= d * MSC && n <= d * (MSC + 1) + 6), 32'h1);
	endtask : lat
	task automatic e_term();
		if (term == TERM_CR || term == TERM_CRLF)
			q_tx.push_back(CH_CR);
		if (term == TERM_CRLF)
			q_tx.push_back(CH_LF);
	endtask : e_term
	task automatic e_hd(input logic [7:0] c, input logic [7:0] s);
		q_tx.push_back(c);
		q_tx.push_back(HOST.hx(s[7:4]));
		q_tx.push_back(HOST.hx(s[3:0]));
	endtask : e_hd
	task automatic e_rd(input logic [15:0] d, input int nd);
		logic [7:0] s;
		logic [7:0] c;
		e_hd(CH_STX, 8'h01);
		s = HOST.hx(4'h0) + HOST.hx(4'h1) + CH_ETX;
		for (int i = nd - 1; i >= 0; i--)
		begin
			c = HOST.hx(d[i*4 +: 4]);
			q_tx.push_back(c);
			s += c;
		end
		e_hd(CH_ETX, s);
		e_term();
	endtask : e_rd
	task automatic pc(input logic [7:0] c, input logic [15:0] d, input logic full);
		q_cmd.push_back({full ? 24'hFFFFFF : 24'hFF0000, c, full ? d : 16'h0});
	endtask : pc
	task automatic wf(input logic [7:0] stn, input logic bad, input int wd);
		v = xs();
		if (bad)
		begin
			e_hd(CH_NAK, stn);
			q_tx.push_back(HOST.hx(ERR_SUM));
		end
		else
		begin
			pc(8'hED, v[15:0], 1'b1);
			e_hd(CH_ACK, stn);
		end
		e_term();
		HOST.req(stn, 8'hED, v[15:0], 4, wd, bad);
	endtask : wf
	initial
	begin
		repeat (12) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		wr(3'h7, 32'hFFFFFFFF);
		foreach (rv[i])
			rd(3'(i), rv[i]);
		wf(8'h00, 1'b0, 2);
		lat(20);
		drain();
		wr(OFS_DELAY, 32'hC8);
		wf(8'h00, 1'b0, -1);
		lat(150);
		drain();
		wr(OFS_DELAY, 32'h0);
		for (int t = 0; t < 4; t++)
		begin
			term <= 2'(t);
			slow <= 1'(t);
			wr(OFS_CFG, 32'h1 | (t << 5));
			wf(8'h01, 1'b0, -1);
			drain();
		end
		HOST.req(8'h02, 8'hED, 16'h1234, 4, -1, 1'b0);
		drain();
		e_hd(CH_NAK, 8'h01);
		q_tx.push_back(HOST.hx(ERR_SUM));
		e_term();
		HOST.req(8'h01, 8'hFF, 16'h05, 2, -1, 1'b1);
		drain();
		rd(OFS_STATUS, 32'h100);
		e_hd(CH_ACK, 8'h01);
		e_term();
		HOST.req(8'h01, 8'hFF, 16'h05, 2, -1, 1'b0);
		drain();
		rd(OFS_STATUS, 32'h50000);
		pc(8'h7F, 16'h0, 1'b0);
		e_rd(16'h05, 2);
		HOST.req(8'h01, 8'h7F, 16'h0, 0, -1, 1'b0);
		drain();
		HOST.ans(1'b1);
		wr(OFS_LIMIT, 32'h2);
		wr(OFS_IRQ_MASK, 32'h4);
		v = xs();
		mon_data_in <= v[31:16];
		slow <= 1'b1;
		pc(8'h6F, 16'h0, 1'b0);
		e_rd(v[31:16], 4);
		HOST.req(8'h01, 8'h6F, 16'h0, 0, -1, 1'b0);
		drain();
		e_rd(v[31:16], 4);
		HOST.ans(1'b0);
		drain();
		HOST.ans(1'b0);
		drain();
		settle();
		chk({31'h0, alarm_out}, 32'h1);
		chk({31'h0, irq_out}, 32'h1);
		rd(OFS_COUNT, 32'h20000);
		rd(OFS_IRQ_ST, 32'h1F);
		wr(OFS_IRQ_ST, 32'h1F);
		wr(OFS_CFG, 32'h161);
		rd(OFS_COUNT, 32'h0);
		settle();
		chk({30'h0, alarm_out, irq_out}, 32'h0);
		// reset instruction is acted on but never answered
		pc(INS_RESET, 16'h9696, 1'b1);
		HOST.req(8'h01, INS_RESET, 16'h9696, 4, -1, 1'b0);
		drain();
		slow <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			wf(8'h01, i != 2, -1);
			drain();
			if (i == 4)
			begin
				rd(OFS_COUNT, 32'h2);
				chk({31'h0, alarm_out}, 32'h0);
			end
		end
		settle();
		chk({31'h0, alarm_out}, 32'h1);
		stop_test();
	end
endmodule : alfh_frame_handler_test

/* File: testbench/alfh_host_model.sv */
// Purpose: host computer model sending request frames and reply answers
// Assumes: one character per strobe cycle, station 01 for answers
// Notes: slow_in spaces characters and stalls reply acceptance
module alfh_host_model
	import alfh_pkg::*;
(
	input wire logic mclk_in, // clock
	input wire logic [1:0] term_in, // terminator choice
	input wire logic slow_in, // stall mode
	output logic [7:0] rx_byte_out, // char to device
	output logic rx_valid_out, // char strobe
	output logic tx_ready_out // reply char taken
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] f[$];
	logic [1:0] st_r = 2'h0;
	initial
	begin
		rx_byte_out = 8'hFF;
		rx_valid_out = 1'b0;
		tx_ready_out = 1'b1;
	end
	always @(posedge mclk_in)
	begin
		st_r <= st_r + 2'h1;
		tx_ready_out <= !slow_in || st_r == 2'h3;
	end
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction : hx
	// an idle line shows the inverse of the last char, so a stale copy cannot pass
	task automatic put();
		logic [7:0] b;
		foreach (f[i])
		begin
			b = f[i];
			@(posedge mclk_in);
			rx_byte_out <= b;
			rx_valid_out <= 1'b1;
			if (slow_in)
			begin
				@(posedge mclk_in);
				rx_byte_out <= ~b;
				rx_valid_out <= 1'b0;
			end
		end
		@(posedge mclk_in);
		rx_byte_out <= ~b;
		rx_valid_out <= 1'b0;
	endtask : put
	task automatic add_term();
		if (term_in == TERM_CR || term_in == TERM_CRLF)
			f.push_back(CH_CR);
		if (term_in == TERM_CRLF)
			f.push_back(CH_LF);
	endtask : add_term
	// bad flips the low sum bit so the device has to reject the frame
	task automatic req(input logic [7:0] stn, input logic [7:0] ins, input logic [15:0] d, input int nd,
		input int wd, input logic bad);
		logic [7:0] s;
		f = {CH_ENQ, hx(stn[7:4]), hx(stn[3:0]), hx(ins[7:4]), hx(ins[3:0])};
		if (wd >= 0)
			f.push_back(hx(4'(wd)));
		for (int i = nd - 1; i >= 0; i--)
			f.push_back(hx(d[i*4 +: 4]));
		s = 8'h00;
		for (int i = 1; i < f.size(); i++)
			s += f[i];
		s ^= {7'h00, bad};
		f.push_back(hx(s[7:4]));
		f.push_back(hx(s[3:0]));
		add_term();
		put();
	endtask : req
	task automatic ans(input logic ack);
		f = {ack ? CH_ACK : CH_NAK, hx(4'h0), hx(4'h1)};
		add_term();
		put();
	endtask : ans
endmodule : alfh_host_model
